//--- design/oqm_axis_if.sv
`timescale 1ns/10ps
`default_nettype none
interface oqm_axis_if;
	logic step;
	logic dir_neg;
	logic hold;
	logic busy;
	logic [1:0] phase;
	modport ctl (output step, output dir_neg, output hold, input busy, input phase);
	modport axis (input step, input dir_neg, input hold, output busy, output phase);
endinterface
`default_nettype wire

//--- design/oqm_pkg.sv
package oqm_pkg;
	// clock rate
	localparam int CLK_MHZ = 100;
	localparam int CLK_NS = 10;
	// power-down timing, in printed units
	localparam int PD_ENTER_NS = 500;
	localparam int PD_PULSE_NS = 1000;
	localparam int WAKE_PD_US = 200;
	localparam int WAKE_POR_US = 400;
	localparam int FRAMES_PD = 128;
	localparam int FRAMES_POR = 124;
	localparam int COMPUTE_MS = 4;
	// derived cycle counts
	localparam int PD_ENTER_CYC = PD_ENTER_NS / CLK_NS;
	localparam int PD_PULSE_CYC = (PD_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_PD_CYC = WAKE_PD_US * CLK_MHZ;
	localparam int WAKE_POR_CYC = WAKE_POR_US * CLK_MHZ;
	localparam int COMPUTE_CYC = COMPUTE_MS * 1000 * CLK_MHZ;
	// frame period default: 3000 frames per second
	localparam int FRAME_CYC_DEF = 33333;
	// counter widths and reset values
	localparam int CNT_W = 24;
	localparam logic [1:0] QUAD_RST = 2'h0;
	localparam logic RES_800 = 1'h0;
	// power sequencing states
	typedef enum logic [2:0] {OQM_START, OQM_WAKE, OQM_FRAMES, OQM_RUN, OQM_ENTER, OQM_DOWN} oqm_pwr_t;
endpackage

//--- design/oqm_quad_axis.sv
`timescale 1ns/10ps
`default_nettype none
module oqm_quad_axis import oqm_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// step port
	oqm_axis_if.axis ax
);
	logic [1:0] state_r;
	// gray walk, one phase per count, reversed when negative
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_r <= QUAD_RST;
		end else if (ax.step && !ax.hold) begin
			unique case ({ax.dir_neg, state_r})
				3'h0: state_r <= 2'h1;
				3'h1: state_r <= 2'h3;
				3'h3: state_r <= 2'h2;
				3'h2: state_r <= 2'h0;
				3'h4: state_r <= 2'h2;
				3'h6: state_r <= 2'h3;
				3'h7: state_r <= 2'h1;
				3'h5: state_r <= 2'h0;
			endcase
		end
	end
	assign ax.phase = state_r;
	assign ax.busy = ax.hold;
endmodule
`default_nettype wire

//--- design/oqm_top.sv
`timescale 1ns/10ps
`default_nettype none
module oqm_top import oqm_pkg::*; #(
	parameter int WAKE_PD_P = WAKE_PD_CYC,
	parameter int WAKE_POR_P = WAKE_POR_CYC,
	parameter int COMPUTE_P = COMPUTE_CYC,
	parameter int FRAME_P = FRAME_CYC_DEF
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// power-down pin from the controller
	input wire logic i_power_down_pin,
	// motion from frame processing, one pulse per frame
	input wire logic i_frame_valid,
	input wire logic signed [7:0] i_delta_x,
	input wire logic signed [7:0] i_delta_y,
	// resolution select, 0 = 800 cpi
	input wire logic i_res_400,
	// quadrature outputs
	output logic o_x_phase_a,
	output logic o_x_phase_b,
	output logic o_y_phase_a,
	output logic o_y_phase_b,
	// status
	output logic o_quad_valid,
	output logic o_reg_valid,
	output logic o_powered_down,
	output logic o_serial_reset,
	output logic o_write_block,
	output logic o_frame_tick
);
	logic pd_s1_r, pd_s2_r, pd_d_r;
	oqm_pwr_t pwr_r;
	logic [CNT_W-1:0] cnt_r;
	logic [7:0] frm_r;
	logic [CNT_W-1:0] fdiv_r;
	logic [CNT_W-1:0] comp_r;
	logic [7:0] pulse_r;
	logic signed [9:0] accx_r, accy_r;
	logic quad_valid_r, reg_valid_r, down_r, sreset_r, wblk_r, tick_r;
	logic xa_r, xb_r, ya_r, yb_r;
	logic pd_rise, pd_fall, hold, tick;
	oqm_axis_if xif();
	oqm_axis_if yif();

	// pin synchroniser
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pd_s1_r <= 1'h0;
			pd_s2_r <= 1'h0;
			pd_d_r <= 1'h0;
		end else begin
			pd_s1_r <= i_power_down_pin;
			pd_s2_r <= pd_s1_r;
			pd_d_r <= pd_s2_r;
		end
	end
	assign pd_rise = pd_s2_r && !pd_d_r;
	assign pd_fall = !pd_s2_r && pd_d_r;
	assign hold = pd_s2_r || down_r;

	// frame period divider, runs only while powered
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || hold || fdiv_r == CNT_W'(FRAME_P - 1)) begin
			fdiv_r <= '0;
		end else begin
			fdiv_r <= fdiv_r + CNT_W'(1);
		end
	end
	assign tick = !hold && fdiv_r == CNT_W'(FRAME_P - 1);

	// power sequencing
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pwr_r <= OQM_START;
			cnt_r <= '0;
			frm_r <= '0;
		end else begin
			unique case (pwr_r)
				OQM_START: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == CNT_W'(WAKE_POR_P - 1)) begin
						pwr_r <= OQM_FRAMES;
						cnt_r <= '0;
						frm_r <= 8'(FRAMES_PD - FRAMES_POR);
					end
				end
				OQM_WAKE: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == CNT_W'(WAKE_PD_P - 1)) begin
						pwr_r <= OQM_FRAMES;
						cnt_r <= '0;
						frm_r <= '0;
					end
				end
				OQM_FRAMES: begin
					if (tick) begin
						frm_r <= frm_r + 8'h01;
						if (frm_r == 8'(FRAMES_PD - 1)) begin
							pwr_r <= OQM_RUN;
						end
					end
				end
				OQM_RUN: ;
				OQM_ENTER: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == CNT_W'(PD_ENTER_CYC - 1)) begin
						pwr_r <= OQM_DOWN;
					end
				end
				OQM_DOWN: ;
			endcase
			if (pd_rise) begin
				pwr_r <= OQM_ENTER;
				cnt_r <= '0;
			end else if (pd_fall) begin
				pwr_r <= OQM_WAKE;
				cnt_r <= '0;
			end
		end
	end

	// status flags
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			quad_valid_r <= 1'h0;
			down_r <= 1'h0;
			wblk_r <= 1'h0;
			tick_r <= 1'h0;
		end else begin
			quad_valid_r <= pwr_r == OQM_RUN && !pd_s2_r;
			down_r <= pwr_r == OQM_DOWN || (pwr_r == OQM_ENTER && cnt_r == CNT_W'(PD_ENTER_CYC - 1));
			wblk_r <= pd_s2_r;
			tick_r <= tick;
		end
	end

	// serial port reset after a long enough pulse
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pulse_r <= '0;
			sreset_r <= 1'h0;
		end else begin
			if (!pd_s2_r) begin
				pulse_r <= '0;
			end else if (pulse_r != 8'(PD_PULSE_CYC)) begin
				pulse_r <= pulse_r + 8'h01;
			end
			sreset_r <= pd_s2_r && pulse_r >= 8'(PD_PULSE_CYC - 1);
		end
	end

	// register data valid after compute time
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			comp_r <= '0;
			reg_valid_r <= 1'h0;
		end else if (pd_s2_r) begin
			comp_r <= '0;
		end else if (comp_r != CNT_W'(COMPUTE_P)) begin
			comp_r <= comp_r + CNT_W'(1);
			if (comp_r == CNT_W'(COMPUTE_P - 1)) begin
				reg_valid_r <= 1'h1;
			end
		end
	end

	// displacement accumulators, drained one count per cycle
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			accx_r <= '0;
			accy_r <= '0;
		end else if (!hold) begin
			accx_r <= accx_r - (xif.step ? (accx_r < 0 ? -10'sd1 : 10'sd1) : 10'sd0)
				+ ((i_frame_valid && pwr_r == OQM_RUN) ? (i_res_400 ? 10'(i_delta_x >>> 1) : 10'(i_delta_x)) : 10'sd0);
			accy_r <= accy_r - (yif.step ? (accy_r < 0 ? -10'sd1 : 10'sd1) : 10'sd0)
				+ ((i_frame_valid && pwr_r == OQM_RUN) ? (i_res_400 ? 10'(i_delta_y >>> 1) : 10'(i_delta_y)) : 10'sd0);
		end
	end

	// step requests to the axis walkers
	assign xif.step = accx_r != 0;
	assign xif.dir_neg = accx_r < 0;
	assign xif.hold = hold;
	assign yif.step = accy_r != 0;
	assign yif.dir_neg = accy_r < 0;
	assign yif.hold = hold;

	oqm_quad_axis u_x (.i_clk(i_clk), .i_reset_n(i_reset_n), .ax(xif));
	oqm_quad_axis u_y (.i_clk(i_clk), .i_reset_n(i_reset_n), .ax(yif));

	// registered phase pins
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			xa_r <= 1'h0;
			xb_r <= 1'h0;
			ya_r <= 1'h0;
			yb_r <= 1'h0;
		end else begin
			xa_r <= xif.phase[0];
			xb_r <= xif.phase[1];
			ya_r <= yif.phase[0];
			yb_r <= yif.phase[1];
		end
	end

	assign o_x_phase_a = xa_r;
	assign o_x_phase_b = xb_r;
	assign o_y_phase_a = ya_r;
	assign o_y_phase_b = yb_r;
	assign o_quad_valid = quad_valid_r;
	assign o_reg_valid = reg_valid_r;
	assign o_powered_down = down_r;
	assign o_serial_reset = sreset_r;
	assign o_write_block = wblk_r;
	assign o_frame_tick = tick_r;
endmodule
`default_nettype wire

//--- dv/oqm_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module oqm_ctl_model (
	// clock and requests
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_pd_req,
	// quadrature inputs
	input wire logic i_xa,
	input wire logic i_xb,
	input wire logic i_ya,
	input wire logic i_yb,
	// pin and decoded counts
	output logic o_power_down_pin,
	output logic signed [15:0] o_cnt_x,
	output logic signed [15:0] o_cnt_y
);
	int hc;
	logic [1:0] px, py;
	// gray index: 00,01,11,10 walk upward
	function automatic logic signed [15:0] stp(input logic [1:0] o, input logic [1:0] n);
		logic [1:0] d;
		d = {n[1], n[1] ^ n[0]} - {o[1], o[1] ^ o[0]};
		return d == 2'h1 ? 16'sh1 : (d == 2'h3 ? -16'sh1 : 16'sh0);
	endfunction
	// pin stays high at least 100 cycles per pulse
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !(i_pd_req || (o_power_down_pin && hc < 100))) begin
			o_power_down_pin <= 1'h0;
			hc <= 0;
		end else begin
			o_power_down_pin <= 1'h1;
			hc <= hc + 1;
		end
	end
	// count quadrature steps per axis
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_cnt_x <= 16'sh0;
			o_cnt_y <= 16'sh0;
			px <= 2'h0;
			py <= 2'h0;
		end else begin
			o_cnt_x <= o_cnt_x + stp(px, {i_xb, i_xa});
			o_cnt_y <= o_cnt_y + stp(py, {i_yb, i_ya});
			px <= {i_xb, i_xa};
			py <= {i_yb, i_ya};
		end
	end
endmodule
`default_nettype wire

//--- dv/oqm_props.sv
`timescale 1ns/10ps
`default_nettype none
module oqm_props (
	// watched top ports
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_power_down_pin,
	input wire logic o_x_phase_a,
	input wire logic o_x_phase_b,
	input wire logic o_y_phase_a,
	input wire logic o_y_phase_b,
	input wire logic o_quad_valid,
	input wire logic o_reg_valid,
	input wire logic o_powered_down,
	input wire logic o_serial_reset,
	input wire logic o_write_block
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic [7:0] blk_cnt_r;
	// cycles the write block has stood high, saturating
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !o_write_block) begin
			blk_cnt_r <= 8'h00;
		end else if (blk_cnt_r != 8'hFF) begin
			blk_cnt_r <= blk_cnt_r + 8'h01;
		end
	end
	// power-down entry follows the blocked pin
	sequence blk_rise;
		$rose(o_write_block);
	endsequence
	sequence down_soon;
		##[45:52] o_powered_down;
	endsequence
	enter_down_a: assert property (blk_rise |-> down_soon) else $error("late power down");
	serial_rst_a: assert property ($rose(o_serial_reset) |-> $past(o_write_block, 8)) else $error("early serial reset");
	serial_wait_a: assert property ($rose(o_serial_reset) |-> blk_cnt_r >= 8'h63) else $error("serial reset pulse short");
	quad_off_a: assert property (o_powered_down |-> !o_quad_valid) else $error("quad valid while down");
	phase_freeze_a: assert property (o_write_block |=> $stable({o_x_phase_a, o_x_phase_b, o_y_phase_a, o_y_phase_b}))
		else $error("phase moved in hold");
	gray_x_a: assert property ($countones({o_x_phase_a, o_x_phase_b} ^ $past({o_x_phase_a, o_x_phase_b})) < 2)
		else $error("x not gray");
	gray_y_a: assert property ($countones({o_y_phase_a, o_y_phase_b} ^ $past({o_y_phase_a, o_y_phase_b})) < 2)
		else $error("y not gray");
	block_on_a: assert property (i_power_down_pin[*5] |-> o_write_block) else $error("write not blocked");
	block_off_a: assert property ((!i_power_down_pin)[*5] |-> !o_write_block) else $error("write still blocked");
	reg_keep_a: assert property (!$fell(o_reg_valid)) else $error("register data lost");
endmodule
bind oqm_top oqm_props oqm_props_i (.i_clk, .i_reset_n, .i_power_down_pin, .o_x_phase_a, .o_x_phase_b,
	.o_y_phase_a, .o_y_phase_b, .o_quad_valid, .o_reg_valid, .o_powered_down, .o_serial_reset, .o_write_block);
`default_nettype wire

//--- dv/test_optical_motion_quadrature_power_down.sv
`timescale 1ns/10ps
`default_nettype none
module test_optical_motion_quadrature_power_down;
	import oqm_pkg::*;
	localparam int POR_C = 40 + FRAMES_POR * 50;
	localparam int PD_C = 20 + FRAMES_PD * 50;
	logic i_clk, i_reset_n, pd_req, fv, res, pin, xa, xb, ya, yb, qv, rv, pdn, srst, wb, ft;
	logic signed [7:0] dx, dy;
	logic signed [15:0] cx, cy;
	int n_fail, check_count, tmo, i;
	oqm_top #(.WAKE_PD_P(20), .WAKE_POR_P(40), .COMPUTE_P(400), .FRAME_P(50)) oqm_top_i (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_power_down_pin(pin), .i_frame_valid(fv), .i_delta_x(dx), .i_delta_y(dy),
		.i_res_400(res), .o_x_phase_a(xa), .o_x_phase_b(xb), .o_y_phase_a(ya), .o_y_phase_b(yb),
		.o_quad_valid(qv), .o_reg_valid(rv), .o_powered_down(pdn), .o_serial_reset(srst),
		.o_write_block(wb), .o_frame_tick(ft));
	oqm_ctl_model oqm_ctl_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_pd_req(pd_req), .i_xa(xa),
		.i_xb(xb), .i_ya(ya), .i_yb(yb), .o_power_down_pin(pin), .o_cnt_x(cx), .o_cnt_y(cy));
	// clock
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end
	// hang guard
	always @(posedge i_clk) begin
		tmo++;
		if (tmo == 30000) begin
			n_fail++;
			finish_test();
		end
	end
	task finish_test();
		if (n_fail == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task move(input logic signed [7:0] x, input logic signed [7:0] y);
		dx = x;
		dy = y;
		fv = 1'h1;
		cyc(1);
		fv = 1'h0;
		cyc(300);
	endtask
	task wait_qv(input int lo, input int hi);
		cyc(lo);
		chk(qv, 16'h0);
		for (i = lo; i < hi && qv !== 1'h1; i++) cyc(1);
		chk(qv, 16'h1);
	endtask
	// frame tick stands one cycle in every frame period
	task t_tick();
		for (i = 0; i < 60 && ft !== 1'h1; i++) cyc(1);
		chk(ft, 16'h1);
		cyc(1);
		chk(ft, 16'h0);
		cyc(48);
		chk(ft, 16'h0);
		cyc(1);
		chk(ft, 16'h1);
	endtask
	// power-on wake, then motion at both resolutions
	task t_por_move();
		cyc(390);
		chk(rv, 16'h0);
		cyc(20);
		chk(rv, 16'h1);
		wait_qv(POR_C - 500, POR_C - 300);
		chk(rv, 16'h1);
		move(3, -2);
		chk(cx, 16'h3);
		chk(cy, 16'hFFFE);
		res = 1'h1;
		move(4, 6);
		chk(cx, 16'h5);
		chk(cy, 16'h1);
		res = 1'h0;
	endtask
	// power-down hold, wake and resume
	task t_pd();
		pd_req = 1'h1;
		cyc(60);
		chk(pdn, 16'h1);
		move(5, 5);
		chk(srst, 16'h1);
		chk(wb, 16'h1);
		chk(cx, 16'h5);
		pd_req = 1'h0;
		wait_qv(PD_C - 90, PD_C + 110);
		chk(rv, 16'h1);
		chk(srst, 16'h0);
		cyc(FRAMES_PD * 50);
		move(-1, 0);
		chk(cx, 16'h4);
	endtask
	initial begin
		{i_reset_n, pd_req, fv, res, dx, dy} = '0;
		n_fail = 0;
		check_count = 0;
		tmo = 0;
		cyc(5);
		i_reset_n = 1'h1;
		chk({xa, xb, ya, yb, qv, pdn, rv, srst, wb, ft}, 16'h0);
		t_por_move();
		t_tick();
		t_pd();
		finish_test();
	end
endmodule
`default_nettype wire
